// file: core/pes_core.sv
// Event status, event enable and link configuration registers with interrupt pin, on Wishbone.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/100ps
module pes_core
   import pes_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [pes_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Asynchronous event levels, one pulse or rising level edge per event
   input wire logic neg_error_i,
   input wire logic rate_change_i,
   input wire logic duplex_change_i,
   input wire logic page_received_i,
   input wire logic neg_done_i,
   input wire logic link_change_i,
   input wire logic false_carrier_i,
   input wire logic pair_swap_change_i,
   input wire logic downshift_event_i,
   input wire logic sleep_change_i,
   input wire logic wake_packet_i,
   input wire logic parallel_mac_error_i,
   input wire logic serial_mac_error_i,
   input wire logic pair_polarity_change_i,
   input wire logic jabber_i,
   // Configuration outputs
   output logic downshift_enable_o,
   output logic downshift_energy_mode_o,
   output logic serial_mac_neg_enable_o,
   output logic downshift_to_ten_enable_o,
   output logic [1:0] downshift_try_count_o,
   // Interrupt pin
   output logic irq_o
);
   import pes_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [15:0] raw_events;
   logic [15:0] sync_events;
   logic [15:0] prev_events;
   logic [15:0] event_hit;
   logic [15:0] event_status;
   logic [15:0] event_enable_reg;
   logic [15:0] link_and_irq_config;
   logic [1:0] downshift_try_count;
   logic bus_req;
   logic bus_rd;
   logic bus_wr;
   logic status_rd;
   logic [31:0] next_rdata;
   logic next_irq;

   // Merges one word under Wishbone byte selects.
   function automatic logic [15:0] sel_merge(input logic [15:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel, input logic [15:0] wmask);
      logic [15:0] m;
      m = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
      sel_merge = (old_v & ~m) | (new_v[15:0] & m);
   endfunction : sel_merge

   always_comb begin
      raw_events = '0;
      raw_events[EV_NEG_ERR] = neg_error_i;
      raw_events[EV_RATE] = rate_change_i;
      raw_events[EV_DUPLEX] = duplex_change_i;
      raw_events[EV_PAGE] = page_received_i;
      raw_events[EV_NEG_DONE] = neg_done_i;
      raw_events[EV_LINK] = link_change_i;
      raw_events[EV_FALSE_CARRIER] = false_carrier_i;
      raw_events[EV_PAIR_SWAP] = pair_swap_change_i;
      raw_events[EV_DOWNSHIFT] = downshift_event_i;
      raw_events[EV_SLEEP] = sleep_change_i;
      raw_events[EV_WAKE] = wake_packet_i;
      raw_events[EV_MAC_ERR] = parallel_mac_error_i | serial_mac_error_i;
      raw_events[EV_POLARITY] = pair_polarity_change_i;
      raw_events[EV_JABBER] = jabber_i;
   end

   // Sources sit outside this clock, so each level is synchronised before edge detection.
   pes_sync2 #(.W(16)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(raw_events),
      .sync_o(sync_events)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_events <= '0;
      end else begin
         prev_events <= sync_events;
      end
   end

   // A rising edge of a source counts as one event.
   assign event_hit = sync_events & ~prev_events & EV_MASK;

   ////////////////////////////////////////////////////////////////////////////
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_rd = bus_req & ~wb_we_i;
   assign bus_wr = bus_req & wb_we_i;
   assign status_rd = bus_rd & (wb_adr_i == ADDR_STATUS);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // Status latches independent of enables; a new event in the read cycle survives.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         event_status <= '0;
      end else if (status_rd) begin
         event_status <= event_hit;
      end else begin
         event_status <= event_status | event_hit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         event_enable_reg <= '0;
      end else if (bus_wr && wb_adr_i == ADDR_ENABLE) begin
         event_enable_reg <= sel_merge(event_enable_reg, wb_dat_i, wb_sel_i, EV_MASK);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         link_and_irq_config <= CF_RESET & CF_WR_MASK;
      end else if (bus_wr && wb_adr_i == ADDR_CONFIG) begin
         // Only writable bits change; reserved and read-only fields ignore writes.
         link_and_irq_config <= sel_merge(link_and_irq_config, wb_dat_i, wb_sel_i, CF_WR_MASK);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         downshift_try_count <= TRY_CODE_RESET;
      end
   end

   always_comb begin
      next_rdata = UNMAPPED_READ;
      if (wb_adr_i == ADDR_STATUS) begin
         next_rdata[15:0] = event_status;
      end else if (wb_adr_i == ADDR_ENABLE) begin
         next_rdata[15:0] = event_enable_reg;
      end else if (wb_adr_i == ADDR_CONFIG) begin
         next_rdata[15:0] = link_and_irq_config;
         next_rdata[CF_TRY_LO +: 2] = downshift_try_count;
         next_rdata[5:0] = CF_LOW_RO;
      end else if (wb_adr_i == ADDR_MASKED) begin
         next_rdata[15:0] = event_status & event_enable_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (bus_rd) begin
         wb_dat_o <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign next_irq = |(event_status & event_enable_reg);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= CF_RESET[CF_IRQ_POL];
      end else begin
         irq_o <= next_irq ^ link_and_irq_config[CF_IRQ_POL];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         downshift_enable_o <= CF_RESET[CF_DS_EN];
         downshift_energy_mode_o <= CF_RESET[CF_DS_ENERGY];
         serial_mac_neg_enable_o <= CF_RESET[CF_SMAC_NEG];
         downshift_to_ten_enable_o <= CF_RESET[CF_DS_TEN];
         downshift_try_count_o <= TRY_CODE_RESET;
      end else begin
         downshift_enable_o <= link_and_irq_config[CF_DS_EN];
         downshift_energy_mode_o <= link_and_irq_config[CF_DS_ENERGY];
         serial_mac_neg_enable_o <= link_and_irq_config[CF_SMAC_NEG];
         downshift_to_ten_enable_o <= link_and_irq_config[CF_DS_TEN];
         downshift_try_count_o <= downshift_try_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_status_latch: assert property (@(posedge clk_i) disable iff (rst_i)
      (event_status[EV_LINK] && !status_rd) |=> event_status[EV_LINK])
      else $error("Status bit lost without a read.");
   a_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      (status_rd && !event_hit[EV_JABBER]) |=> !event_status[EV_JABBER])
      else $error("Status bit not cleared by read.");
   a_set_unmasked: assert property (@(posedge clk_i) disable iff (rst_i)
      (event_hit[EV_WAKE] && !event_enable_reg[EV_WAKE]) |=> event_status[EV_WAKE])
      else $error("Event not recorded while disabled.");
   a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      event_status[9] == 1'b0 && event_status[7] == 1'b0)
      else $error("Reserved status bit set.");
   a_mac_either: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(sync_events[EV_MAC_ERR]) |=> event_status[EV_MAC_ERR])
      else $error("MAC error not recorded.");
   a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      (|(event_status & event_enable_reg)) |=> (irq_o == !$past(link_and_irq_config[CF_IRQ_POL])))
      else $error("Interrupt pin not asserted.");
   a_irq_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !(|(event_status & event_enable_reg)) |=> (irq_o == $past(link_and_irq_config[CF_IRQ_POL])))
      else $error("Interrupt pin asserted without enabled event.");
   a_cfg_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
      link_and_irq_config[15:14] == 2'b00)
      else $error("Reserved config bits set.");
   a_try_const: assert property (@(posedge clk_i) disable iff (rst_i)
      downshift_try_count_o == TRY_CODE_RESET)
      else $error("Try count code changed.");
   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("Ack held two cycles.");

   ////////////////////////////////////////////////////////////////////////////
   // Steps for the checks below, only s_cfg_read used by two; an edge needs two samples of the synchronised level.
   sequence s_link_rise;
      !sync_events[EV_LINK] ##1 sync_events[EV_LINK];
   endsequence : s_link_rise

   sequence s_jabber_rise;
      !sync_events[EV_JABBER] ##1 sync_events[EV_JABBER];
   endsequence : s_jabber_rise

   sequence s_cfg_read;
      bus_rd && wb_adr_i == ADDR_CONFIG;
   endsequence : s_cfg_read

   sequence s_cfg_write;
      bus_wr && wb_adr_i == ADDR_CONFIG;
   endsequence : s_cfg_write

   // A read that leaves nothing enabled pending; the pin must let go one cycle later.
   sequence s_read_drains;
      status_rd ##1 ((event_status & event_enable_reg) == 16'h0000);
   endsequence : s_read_drains

   // Status bits appear only through events, and a read hands over what was latched.
   a_link_records: assert property (@(posedge clk_i) disable iff (rst_i)
      s_link_rise |=> event_status[EV_LINK])
      else $error("Link event not recorded.");
   a_jabber_records: assert property (@(posedge clk_i) disable iff (rst_i)
      s_jabber_rise |=> event_status[EV_JABBER])
      else $error("Jabber event not recorded.");
   a_no_spurious: assert property (@(posedge clk_i) disable iff (rst_i)
      (event_status & ~$past(event_status) & ~$past(event_hit)) == 16'h0000)
      else $error("Status bit set without an event.");
   a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      (status_rd && event_hit[EV_LINK]) |=> event_status[EV_LINK])
      else $error("Event lost in the read cycle.");
   a_read_empties: assert property (@(posedge clk_i) disable iff (rst_i)
      (status_rd && event_hit == 16'h0000) |=> event_status == 16'h0000)
      else $error("Status not emptied by read.");
   a_read_returns: assert property (@(posedge clk_i) disable iff (rst_i)
      status_rd |=> wb_dat_o[15:0] == $past(event_status))
      else $error("Status read returned wrong bits.");
   a_enable_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
      (event_enable_reg & ~EV_MASK) == 16'h0000)
      else $error("Reserved enable bit set.");

   // Configuration reads show the fixed fields, and only a write moves the writable ones.
   a_cfg_try_read: assert property (@(posedge clk_i) disable iff (rst_i)
      s_cfg_read |=> wb_dat_o[CF_TRY_LO +: 2] == TRY_CODE_RESET)
      else $error("Try count field read wrong.");
   a_cfg_zero_read: assert property (@(posedge clk_i) disable iff (rst_i)
      s_cfg_read |=> (wb_dat_o[15:0] & ~CF_RESET & ~CF_WR_MASK) == 16'h0000 && wb_dat_o[31:16] == 16'h0000)
      else $error("Reserved config bits read nonzero.");
   a_pol_write: assert property (@(posedge clk_i) disable iff (rst_i)
      s_cfg_write |=> link_and_irq_config[CF_IRQ_POL] ==
         ($past(wb_sel_i[1]) ? $past(wb_dat_i[CF_IRQ_POL]) : $past(link_and_irq_config[CF_IRQ_POL])))
      else $error("Polarity write not taken.");
   a_cfg_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !(bus_wr && wb_adr_i == ADDR_CONFIG) |=> $stable(link_and_irq_config))
      else $error("Configuration changed without a write.");
   a_ds_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      downshift_enable_o == $past(link_and_irq_config[CF_DS_EN]))
      else $error("Downshift enable output wrong.");
   a_energy_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      downshift_energy_mode_o == $past(link_and_irq_config[CF_DS_ENERGY]))
      else $error("Energy mode output wrong.");
   a_neg_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      serial_mac_neg_enable_o == $past(link_and_irq_config[CF_SMAC_NEG]))
      else $error("Serial negotiation output wrong.");
   a_ten_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      downshift_to_ten_enable_o == $past(link_and_irq_config[CF_DS_TEN]))
      else $error("Downshift to ten output wrong.");

   // The pin follows the enabled pending set, and the masked view agrees with it.
   a_drain_release: assert property (@(posedge clk_i) disable iff (rst_i)
      s_read_drains |=> irq_o == $past(link_and_irq_config[CF_IRQ_POL]))
      else $error("Interrupt pin held after read.");
   a_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (bus_wr && wb_adr_i == ADDR_ENABLE && wb_sel_i[1]) |=>
         event_enable_reg[EV_LINK] == $past(wb_dat_i[EV_LINK]))
      else $error("Enable write not taken.");
   a_masked_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (bus_rd && wb_adr_i == ADDR_MASKED) |=> wb_dat_o[15:0] == ($past(event_status) & $past(event_enable_reg)))
      else $error("Masked pending view wrong.");

   // Every taken request is answered on the next edge, and never otherwise.
   a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_req |=> wb_ack_o)
      else $error("Request not acknowledged.");
   a_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> $past(bus_req))
      else $error("Ack without a request.");
endmodule : pes_core

// file: core/pes_pkg.sv
// Package with register map, field layout and reset values of the event status block.
package pes_pkg;
   // Register byte addresses (printed offsets are not multiples of four, so index times four).
   localparam logic [7:0] IDX_ENABLE = 8'h12;
   localparam logic [7:0] IDX_STATUS = 8'h13;
   localparam logic [7:0] IDX_CONFIG = 8'h14;
   localparam logic [7:0] IDX_MASKED = 8'h15;
   localparam int unsigned ADDR_W = 10;
   localparam logic [ADDR_W-1:0] ADDR_ENABLE = {IDX_ENABLE, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_CONFIG = {IDX_CONFIG, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_MASKED = {IDX_MASKED, 2'b00};
   // Event bit positions in the status and enable registers.
   localparam int unsigned EV_NEG_ERR = 15;
   localparam int unsigned EV_RATE = 14;
   localparam int unsigned EV_DUPLEX = 13;
   localparam int unsigned EV_PAGE = 12;
   localparam int unsigned EV_NEG_DONE = 11;
   localparam int unsigned EV_LINK = 10;
   localparam int unsigned EV_FALSE_CARRIER = 8;
   localparam int unsigned EV_PAIR_SWAP = 6;
   localparam int unsigned EV_DOWNSHIFT = 5;
   localparam int unsigned EV_SLEEP = 4;
   localparam int unsigned EV_WAKE = 3;
   localparam int unsigned EV_MAC_ERR = 2;
   localparam int unsigned EV_POLARITY = 1;
   localparam int unsigned EV_JABBER = 0;
   // Implemented event bits; bits 9 and 7 are reserved.
   localparam logic [15:0] EV_MASK = 16'hFD7F;
   // Configuration register fields.
   localparam int unsigned CF_IRQ_POL = 13;
   localparam int unsigned CF_TRY_LO = 10;
   localparam int unsigned CF_DS_EN = 9;
   localparam int unsigned CF_DS_ENERGY = 8;
   localparam int unsigned CF_SMAC_NEG = 7;
   localparam int unsigned CF_DS_TEN = 6;
   localparam logic [15:0] CF_WR_MASK = 16'h23C0;
   localparam logic [15:0] CF_RESET = 16'h29C7;
   localparam logic [1:0] TRY_CODE_RESET = 2'h2;
   localparam logic [5:0] CF_LOW_RO = 6'h07;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : pes_pkg

// file: core/pes_sync2.sv
// Two-flop synchroniser for a vector of asynchronous event levels.
`timescale 1ns/100ps
module pes_sync2 #(
   parameter int unsigned W = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Levels
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] stage1;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage1 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule : pes_sync2

// file: bench/pes_host_model.sv
// Wishbone classic master standing in for the management software.
`timescale 1ns/100ps
module pes_host_model
   import pes_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Wishbone master side
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [pes_pkg::ADDR_W-1:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o,
   input wire logic [31:0] dat_i,
   input wire logic ack_i
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = '0;
      sel_o = 4'h0;
      dat_o = 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One classic cycle; the request stands until ack is sampled high.
   task automatic access(input logic we, input logic [ADDR_W-1:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= we;
      adr_o <= adr;
      sel_o <= 4'h3;
      dat_o <= wd;
      do begin
         @(posedge clk_i);
      end while (ack_i !== 1'b1);
      rd = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= 1'b0;
      // Released data is scrambled so that a slave latching it late is seen.
      dat_o <= ~wd;
   endtask : access
endmodule : pes_host_model

// file: bench/pes_core_test.sv
// Self-checking bench for the event status and configuration block.
`timescale 1ns/100ps
module pes_core_test;
   import pes_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, stb, we, ack, irq, ds_en, ds_energy, smac_neg, ds_ten;
   logic [ADDR_W-1:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, rd;
   logic [14:0] ev = '0;
   logic [1:0] try_cnt;
   int n_mismatch = 0;
   int check_count = 0;
   // Status bit raised by each event input, in the order of the ev vector.
   int ev_bit [15] = '{15, 14, 13, 12, 11, 10, 8, 6, 5, 4, 3, 2, 2, 1, 0};

   always #10 clk_i = ~clk_i;

   pes_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .neg_error_i(ev[0]), .rate_change_i(ev[1]), .duplex_change_i(ev[2]), .page_received_i(ev[3]),
      .neg_done_i(ev[4]), .link_change_i(ev[5]), .false_carrier_i(ev[6]), .pair_swap_change_i(ev[7]),
      .downshift_event_i(ev[8]), .sleep_change_i(ev[9]), .wake_packet_i(ev[10]),
      .parallel_mac_error_i(ev[11]), .serial_mac_error_i(ev[12]), .pair_polarity_change_i(ev[13]),
      .jabber_i(ev[14]), .downshift_enable_o(ds_en), .downshift_energy_mode_o(ds_energy),
      .serial_mac_neg_enable_o(smac_neg), .downshift_to_ten_enable_o(ds_ten),
      .downshift_try_count_o(try_cnt), .irq_o(irq));

   pes_host_model host_u (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
      .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      host_u.access(1'b0, a, 32'h0000_0000, rd);
      chk(rd, exp);
   endtask : rd_chk

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      host_u.access(1'b1, a, d, rd);
   endtask : wr

   // Inputs need a quiet gap after each edge, so the pulse ends with idle cycles.
   task automatic pulse(input int i);
      @(posedge clk_i);
      ev[i] <= 1'b1;
      repeat (3) @(posedge clk_i);
      ev[i] <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask : pulse

   task automatic end_of_test;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      end_of_test();
   end

   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(ADDR_CONFIG, 32'h0000_29C7);
      rd_chk(ADDR_STATUS, 32'h0000_0000);
      chk(32'({ds_en, ds_energy, smac_neg, ds_ten, try_cnt, irq}), 32'h0000_003D);
      wr(ADDR_CONFIG, 32'hFFFF_FFFF);
      rd_chk(ADDR_CONFIG, 32'h0000_2BC7);
      chk(32'({ds_en, ds_energy, smac_neg, ds_ten, try_cnt, irq}), 32'h0000_007D);
      wr(ADDR_CONFIG, 32'h0000_0000);
      rd_chk(ADDR_CONFIG, 32'h0000_0807);
      chk(32'({ds_en, ds_energy, smac_neg, ds_ten, try_cnt, irq}), 32'h0000_0004);
      rd_chk(10'h3FC, 32'h0000_0000);
      wr(10'h3FC, 32'hFFFF_FFFF);
      wr(ADDR_STATUS, 32'hFFFF_FFFF);
      rd_chk(ADDR_STATUS, 32'h0000_0000);
      wr(ADDR_ENABLE, 32'hFFFF_FFFF);
      rd_chk(ADDR_ENABLE, 32'h0000_FD7F);
      wr(ADDR_ENABLE, 32'h0000_0000);
      // Every event with all enables off: the bit latches, the pin stays idle.
      foreach (ev_bit[i]) begin
         pulse(i);
         chk(32'(irq), 32'h0000_0000);
         rd_chk(ADDR_STATUS, 32'h0000_0001 << ev_bit[i]);
         rd_chk(ADDR_STATUS, 32'h0000_0000);
      end
      // Pin is active high now; only the link event is allowed through.
      wr(ADDR_ENABLE, 32'h0000_0400);
      pulse(14);
      chk(32'(irq), 32'h0000_0000);
      pulse(5);
      chk(32'(irq), 32'h0000_0001);
      wr(ADDR_CONFIG, 32'h0000_2000);
      repeat (2) @(posedge clk_i);
      chk(32'(irq), 32'h0000_0000);
      rd_chk(ADDR_MASKED, 32'h0000_0400);
      rd_chk(ADDR_STATUS, 32'h0000_0401);
      repeat (2) @(posedge clk_i);
      chk(32'(irq), 32'h0000_0001);
      end_of_test();
   end
endmodule : pes_core_test
